// file: itc_pkg.sv
// package: register map, fields and types for the interval counter block
`default_nettype none
package counter_match_pkg;
    // register byte offsets (32-bit words over the bus)
    localparam logic [7:0] OFF_COUNT_LO   = 8'h00;
    localparam logic [7:0] OFF_COUNT_HI   = 8'h04;
    localparam logic [7:0] OFF_MATCH_LO   = 8'h08;
    localparam logic [7:0] OFF_MATCH_HI   = 8'h0C;
    localparam logic [7:0] OFF_CONTROL    = 8'h10;
    localparam logic [7:0] OFF_STATUS     = 8'h14;
    localparam logic [7:0] OFF_ACCESS     = 8'h18;

    // control fields
    localparam int CTL_SECURE_BIT   = 0;
    localparam int CTL_LEGACY_DIS   = 1;
    localparam int CTL_LEGACY_MODE  = 2;
    // access word fields: privilege level in bits 1:0
    localparam int ACC_PL_LSB       = 0;
    // status fields
    localparam int ST_PENDING       = 0;
    localparam int ST_PRIV_REG      = 1;
    localparam int ST_PRIV_OP       = 2;
    localparam int ST_GP_FAULT      = 3;

    localparam logic [63:0] COUNT_RESET   = 64'h0000_0000_0000_0000;
    localparam logic [63:0] MATCH_RESET   = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [2:0]  CONTROL_RESET = 3'h0;
    localparam logic [1:0]  PL_RESET      = 2'h0;
    localparam int          TICK_DIV      = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       secure;
        logic       legacy_dis;
        logic       legacy_mode;
        logic [1:0] priv_level;
    } access_ctx_t;

    typedef struct packed {
        logic priv_op;
        logic priv_reg;
        logic gp_fault;
    } fault_flags_t;
endpackage : counter_match_pkg
`default_nettype wire

// file: interval_time_counter_match.sv
// interval counter with match interrupt behind an AXI4-Lite slave
// What this block does
// - free-running 64-bit counter on divided clock
// - counter wraps silently, no overflow flag
// - rate unaffected by any power state
// - counter may tick slower than accesses
// - counter readable at any level unsecured, except above level zero in legacy mode with legacy disable set
// - secured non-privileged read gives register fault, general fault in legacy mode
// - counter writes only at level zero
// - legacy timestamp read returns counter value
// - legacy secured read above level zero faults
// - interrupt when counter equals match value
// - match access only at level zero
// - updates visible after software serialization
`timescale 1ns/1ps
`default_nettype none
module interval_time_counter_match
    import counter_match_pkg::*;
#(
    parameter int TICK_DIVIDE = TICK_DIV
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        timer_ack,
    output logic             timer_irq
);
    localparam int DW = (TICK_DIVIDE > 1) ? $clog2(TICK_DIVIDE) : 1;

    logic [63:0]   interval_counter_reg;
    logic [63:0]   timer_match_value_reg;
    access_ctx_t   ctx_reg;
    fault_flags_t  fault_reg;
    logic [DW-1:0] div_reg;
    logic          tick;
    logic          aw_held_reg;
    logic          w_held_reg;
    logic [7:0]    awaddr_reg;
    logic [31:0]   wdata_reg;
    logic [3:0]    wstrb_reg;
    logic          do_write;
    logic          privileged;
    logic          cnt_rd_ok;
    logic          wr_ok;
    logic          wr_cnt_lo;
    logic          wr_cnt_hi;
    logic          rd_ok;
    logic [31:0]   rd_word;
    fault_flags_t  wr_fault;
    fault_flags_t  rd_fault;
    logic          do_read;

    // fixed divider
    // no enable input exists, so no power state can slow the count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_reg <= '0;
        else if (div_reg == DW'(TICK_DIVIDE - 1))
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end
    assign tick = (div_reg == DW'(TICK_DIVIDE - 1));

    // write address and data captured independently, in either order
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_reg <= 1'b0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        else if (do_write)
            w_held_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    assign privileged = (ctx_reg.priv_level == 2'h0);
    assign cnt_rd_ok  = !ctx_reg.secure || privileged;
    assign wr_ok      = privileged;
    assign wr_cnt_lo  = do_write && wr_ok && (awaddr_reg == OFF_COUNT_LO);
    assign wr_cnt_hi  = do_write && wr_ok && (awaddr_reg == OFF_COUNT_HI);

    // write decode and fault classification
    always_comb
    begin
        wr_fault = '0;
        if (do_write && !wr_ok)
        begin
            unique case (awaddr_reg)
                OFF_COUNT_LO, OFF_COUNT_HI: wr_fault.priv_reg = 1'b1;
                OFF_MATCH_LO, OFF_MATCH_HI: wr_fault.priv_op  = 1'b1;
                default:                    wr_fault          = '0;
            endcase
        end
    end

    // count, wrap, load
    // a write wins over the tick in the same cycle; only the written half changes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            interval_counter_reg <= COUNT_RESET;
        else if (wr_cnt_lo)
            interval_counter_reg[31:0] <= wdata_reg;
        else if (wr_cnt_hi)
            interval_counter_reg[63:32] <= wdata_reg;
        else if (tick)
            interval_counter_reg <= interval_counter_reg + 64'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_match_value_reg <= MATCH_RESET;
        else if (do_write && wr_ok && awaddr_reg == OFF_MATCH_LO)
            timer_match_value_reg[31:0] <= wdata_reg;
        else if (do_write && wr_ok && awaddr_reg == OFF_MATCH_HI)
            timer_match_value_reg[63:32] <= wdata_reg;
    end

    // context word: models the executing core's privilege state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctx_reg.secure      <= CONTROL_RESET[CTL_SECURE_BIT];
            ctx_reg.legacy_dis  <= CONTROL_RESET[CTL_LEGACY_DIS];
            ctx_reg.legacy_mode <= CONTROL_RESET[CTL_LEGACY_MODE];
            ctx_reg.priv_level  <= PL_RESET;
        end
        else if (do_write && awaddr_reg == OFF_CONTROL && wr_ok && wstrb_reg[0])
        begin
            ctx_reg.secure      <= wdata_reg[CTL_SECURE_BIT];
            ctx_reg.legacy_dis  <= wdata_reg[CTL_LEGACY_DIS];
            ctx_reg.legacy_mode <= wdata_reg[CTL_LEGACY_MODE];
        end
        else if (do_write && awaddr_reg == OFF_ACCESS && wstrb_reg[0])
            ctx_reg.priv_level  <= wdata_reg[ACC_PL_LSB +: 2];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_fault != '0 || awaddr_reg > OFF_ACCESS) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    assign do_read = s_axi_arvalid && s_axi_arready;

    // read decode with permission checks
    always_comb
    begin
        rd_ok    = 1'b1;
        rd_word  = 32'h0000_0000;
        rd_fault = '0;
        unique case (s_axi_araddr)
            OFF_COUNT_LO, OFF_COUNT_HI:
            begin
                if (ctx_reg.legacy_mode && !privileged && (ctx_reg.secure || ctx_reg.legacy_dis))
                begin
                    rd_ok             = 1'b0;
                    rd_fault.gp_fault = 1'b1;
                end
                else if (!ctx_reg.legacy_mode && !cnt_rd_ok)
                begin
                    rd_ok             = 1'b0;
                    rd_fault.priv_reg = 1'b1;
                end
                else if (s_axi_araddr == OFF_COUNT_LO)
                    rd_word = interval_counter_reg[31:0];
                else
                    rd_word = interval_counter_reg[63:32];
            end
            OFF_MATCH_LO, OFF_MATCH_HI:
            begin
                if (!privileged)
                begin
                    rd_ok            = 1'b0;
                    rd_fault.priv_op = 1'b1;
                end
                else if (s_axi_araddr == OFF_MATCH_LO)
                    rd_word = timer_match_value_reg[31:0];
                else
                    rd_word = timer_match_value_reg[63:32];
            end
            OFF_CONTROL:
                rd_word = {29'h0, ctx_reg.legacy_mode, ctx_reg.legacy_dis, ctx_reg.secure};
            OFF_STATUS:
                rd_word = {28'h0, fault_reg.gp_fault, fault_reg.priv_op, fault_reg.priv_reg, timer_irq};
            OFF_ACCESS:
                rd_word = {30'h0, ctx_reg.priv_level};
            default:
                rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !do_read;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // sticky fault flags; a new fault wins over the clearing write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fault_reg <= '0;
        else if (do_write && awaddr_reg == OFF_STATUS && wr_ok)
            fault_reg <= (fault_reg & ~fault_flags_t'({wdata_reg[ST_PRIV_OP], wdata_reg[ST_PRIV_REG],
                          wdata_reg[ST_GP_FAULT]})) | wr_fault | (do_read ? rd_fault : '0);
        else
            fault_reg <= fault_reg | wr_fault | (do_read ? rd_fault : '0);
    end

    // equality seen one cycle after a load, software serializes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_irq <= 1'b0;
        else if (interval_counter_reg == timer_match_value_reg)
            timer_irq <= 1'b1;
        else if (timer_ack)
            timer_irq <= 1'b0;
    end
endmodule : interval_time_counter_match
`default_nettype wire

// file: itc_chk.sv
// port assertions for the interval counter block
`timescale 1ns/1ps
`default_nettype none
module counter_match_chk
    import counter_match_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        timer_ack,
    input wire logic        timer_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    r_fault_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("faulting read returned data");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write taken");
    irq_keep_a: assert property (timer_irq && !timer_ack |=> timer_irq)
        else $error("pending interrupt lost");
    irq_clear_a: assert property ($fell(timer_irq) && $past(aresetn) |-> $past(timer_ack))
        else $error("interrupt cleared without ack");
endmodule : counter_match_chk
bind interval_time_counter_match counter_match_chk chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_ack(timer_ack), .timer_irq(timer_irq));
`default_nettype wire

// file: timer_ack_model.sv
// interrupt logic model that acknowledges the timer interrupt
`timescale 1ns/1ps
`default_nettype none
module timer_ack_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic timer_irq,
    input wire logic slow,
    output var logic timer_ack
);
    logic [3:0] wait_cnt;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !timer_irq)
        begin
            wait_cnt  <= 4'h0;
            timer_ack <= 1'b0;
        end
        else if (wait_cnt >= (slow ? 4'h6 : 4'h0))
            timer_ack <= 1'b1;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule : timer_ack_model
`default_nettype wire

// file: tb_interval_time_counter_match.sv
// self-checking bench for the interval counter block
`timescale 1ns/1ps
`default_nettype none
module tb_interval_time_counter_match import counter_match_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, v;
    logic [3:0]  wstrb;
    wire logic   awready, wready, bvalid, arready, rvalid, timer_ack, timer_irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    int          miscompares = 0, n_checks = 0, cyc = 0, n;

    // fast tick so the wrap and match come quickly
    interval_time_counter_match #(.TICK_DIVIDE(1)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_ack(timer_ack), .timer_irq(timer_irq));
    timer_ack_model ack_model (.aclk(aclk), .aresetn(aresetn), .timer_irq(timer_irq), .slow(slow),
        .timer_ack(timer_ack));

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        exp_b.push_back(e);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        // a late ready now and then keeps the response hold check busy
        bready  <= 1'($urandom);
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid && !bready)
                bready <= 1'b1;
        end
        while (!(bvalid && bready));
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] d);
        @(posedge aclk);
        exp_r.push_back({e, d});
        araddr  <= a;
        arvalid <= 1'b1;
        // a late ready now and then keeps the data hold check busy
        rready  <= 1'($urandom);
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid && !rready)
                rready <= 1'b1;
        end
        while (!(rvalid && rready));
        rready <= 1'b0;
    endtask : rd

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // answers are paired with the oldest note as they appear
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            test_done;
        end
        if (bvalid && bready)
            chk("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
        if (rvalid && rready)
            chk("read", exp_r.pop_front(), {rresp, rdata});
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        v = $urandom(32'hF8BD);
        v = $urandom;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_MATCH_LO, RESP_OKAY, 32'hFFFF_FFFF);
        rd(OFF_COUNT_HI, RESP_OKAY, 32'h0);
        tend("reset");
        wr(OFF_COUNT_HI, 32'hFFFF_FFFF, RESP_OKAY);
        wr(OFF_COUNT_LO, 32'hFFFF_FFF0, RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(OFF_COUNT_HI, RESP_OKAY, 32'h0);
        rd(OFF_STATUS, RESP_OKAY, 32'h0);
        tend("wrap");
        slow <= 1'b1;
        wr(OFF_MATCH_HI, 32'h0, RESP_OKAY);
        wr(OFF_MATCH_LO, 32'h100, RESP_OKAY);
        wr(OFF_COUNT_HI, 32'h0, RESP_OKAY);
        wr(OFF_COUNT_LO, 32'hC0, RESP_OKAY);
        for (n = 0; !timer_irq && n < 300; n++)
            @(posedge aclk);
        chk("irq delay", 34'h1, {33'h0, n > 57 && n < 71});
        repeat (2) @(posedge aclk);
        chk("irq held", 34'h1, {33'h0, timer_irq});
        for (n = 0; timer_irq && n < 30; n++)
            @(posedge aclk);
        chk("irq clear", 34'h0, {33'h0, timer_irq});
        rd(OFF_STATUS, RESP_OKAY, 32'h0);
        tend("match");
        wr(OFF_COUNT_HI, v, RESP_OKAY);
        wr(OFF_ACCESS, 32'h2, RESP_OKAY);
        wr(OFF_COUNT_HI, ~v, RESP_SLVERR);
        rd(OFF_MATCH_LO, RESP_SLVERR, 32'h0);
        rd(OFF_COUNT_HI, RESP_OKAY, v);
        wr(OFF_ACCESS, 32'h0, RESP_OKAY);
        wr(OFF_CONTROL, 32'h1, RESP_OKAY);
        wr(OFF_ACCESS, 32'h3, RESP_OKAY);
        rd(OFF_COUNT_HI, RESP_SLVERR, 32'h0);
        wr(OFF_ACCESS, 32'h0, RESP_OKAY);
        wr(OFF_CONTROL, 32'h6, RESP_OKAY);
        wr(OFF_ACCESS, 32'h1, RESP_OKAY);
        rd(OFF_COUNT_HI, RESP_SLVERR, 32'h0);
        wr(OFF_ACCESS, 32'h0, RESP_OKAY);
        wr(OFF_CONTROL, 32'h4, RESP_OKAY);
        wr(OFF_ACCESS, 32'h1, RESP_OKAY);
        rd(OFF_COUNT_HI, RESP_OKAY, v);
        wr(OFF_ACCESS, 32'h0, RESP_OKAY);
        rd(OFF_STATUS, RESP_OKAY, 32'hE);
        wr(OFF_STATUS, 32'hE, RESP_OKAY);
        rd(OFF_STATUS, RESP_OKAY, 32'h0);
        rd(8'h1C, RESP_SLVERR, 32'h0);
        tend("access");
        repeat (3) @(posedge aclk);
        test_done;
    end
endmodule : tb_interval_time_counter_match
`default_nettype wire
